// >>> rtl/srcs_consts.vh
// Constants for the reset and clock-source controller
`ifndef SRCS_CONSTS_VH
`define SRCS_CONSTS_VH

// Register byte offsets
`define SRCS_OFF_FAULT_CTL 8'h00
`define SRCS_OFF_CAUSE 8'h04
`define SRCS_OFF_BO_STAT 8'h08
`define SRCS_OFF_SOFT0 8'h0C
`define SRCS_OFF_SOFT1 8'h10
`define SRCS_OFF_SOFT2 8'h14
`define SRCS_OFF_CLK_CFG 8'h18
`define SRCS_OFF_SYS_REQ 8'h1C
`define SRCS_OFF_WD_LOAD 8'h20
`define SRCS_OFF_WD_CTL 8'h24
`define SRCS_OFF_WD_VALUE 8'h28
`define SRCS_OFF_WD_STAT 8'h2C
`define SRCS_OFF_CLK_STAT 8'h30

// Fault control field
`define SRCS_BIT_BO_RESET_EN 1

// Reset cause fields
`define SRCS_CAUSE_EXT 0
`define SRCS_CAUSE_POR 1
`define SRCS_CAUSE_BOR 2
`define SRCS_CAUSE_WDT 3
`define SRCS_CAUSE_SW 4
`define SRCS_CAUSE_POR_VALUE 5'h02

// Clock configuration fields
`define SRCS_BIT_BYPASS 0
`define SRCS_OSC_LSB 1
`define SRCS_EXT_LSB 4
`define SRCS_BIT_USE_EXT 7
`define SRCS_CLK_CFG_RESET 8'h03

// Source select encodings
`define SRCS_OSC_MAIN 2'h0
`define SRCS_OSC_FAST 2'h1
`define SRCS_OSC_FAST_DIV4 2'h2
`define SRCS_OSC_SLOW 2'h3
`define SRCS_EXT_RTC 3'h7

// One-hot clock gate positions
`define SRCS_GATE_PLL 0
`define SRCS_GATE_MAIN 1
`define SRCS_GATE_FAST 2
`define SRCS_GATE_FAST_DIV4 3
`define SRCS_GATE_SLOW 4
`define SRCS_GATE_RTC 5
`define SRCS_GATE_RESET 6'h04

// Watchdog control fields
`define SRCS_BIT_WD_RUN 0
`define SRCS_BIT_WD_RESET_EN 1
`define SRCS_WD_LOAD_RESET 32'hFFFFFFFF

// Timing counts in system clock cycles
`define SRCS_RESET_STRETCH 5'h10
`define SRCS_CLK_GAP 3'h4

`endif

// >>> rtl/srcs_reset_clock_ctl.v
// Reset sequencer, watchdog, brown-out handling and clock-source selection
//
// The placing of the registers and the APB interface to the registers are this design's own decisions.
`timescale 1ns/1ns
`include "srcs_consts.vh"

module srcs_reset_clock_ctl (
  // Clock and power-on reset
  input wire clock,
  input wire reset,
  // APB slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output wire pready,
  output reg [31:0] prdata,
  output reg pslverr,
  // Reset sources and main oscillator ready status
  input wire extResetN,
  input wire supplyLow,
  input wire mainOscReady,
  // Reset outputs
  output reg coreReset,
  output reg testAccessReset,
  output reg [95:0] periphReset,
  // Interrupt levels to the controller
  output reg brownoutIrq,
  output reg watchdogIrq,
  // One-hot clock gate enables: PLL, main, fast, fast/4, slow, rtc
  output reg [5:0] clockGate,
  output reg pllFromMain
);

  // Reset sequencer states
  localparam ST_RUN = 3'b001;
  localparam ST_HOLD = 3'b010;
  localparam ST_STRETCH = 3'b100;

  // Decode a clock configuration into a one-hot gate vector
  function [5:0] srcsClkDecode;
    input [7:0] cfg;
    begin
      srcsClkDecode = 6'h00;
      if (!cfg[`SRCS_BIT_BYPASS]) begin
        // PLL only exists with the main oscillator as its reference
        srcsClkDecode[`SRCS_GATE_PLL] = 1'b1;
      end else if (cfg[`SRCS_BIT_USE_EXT] &&
                   cfg[`SRCS_EXT_LSB+2:`SRCS_EXT_LSB] == `SRCS_EXT_RTC) begin
        srcsClkDecode[`SRCS_GATE_RTC] = 1'b1;
      end else begin
        case (cfg[`SRCS_OSC_LSB+1:`SRCS_OSC_LSB])
          `SRCS_OSC_MAIN: srcsClkDecode[`SRCS_GATE_MAIN] = 1'b1;
          `SRCS_OSC_FAST: srcsClkDecode[`SRCS_GATE_FAST] = 1'b1;
          `SRCS_OSC_FAST_DIV4: srcsClkDecode[`SRCS_GATE_FAST_DIV4] = 1'b1;
          default: srcsClkDecode[`SRCS_GATE_SLOW] = 1'b1;
        endcase
      end
    end
  endfunction

  // Register state
  reg borEnable_reg;
  reg [4:0] cause_reg;
  reg borFlag_reg;
  reg [31:0] soft0_reg;
  reg [31:0] soft1_reg;
  reg [31:0] soft2_reg;
  reg [7:0] clkCfg_reg;
  reg [31:0] wdLoad_reg;
  reg [1:0] wdCtl_reg;
  reg [31:0] wdCount_reg;
  reg wdFlag_reg;
  reg sysReq_reg;
  reg wdReset_reg;
  reg supplyLowDly_reg;
  reg [2:0] state_reg;
  reg [2:0] state_next;
  reg [4:0] stretch_reg;
  reg [2:0] gap_reg;

  // Bus decode
  wire setup = psel && !penable;
  wire wrStrobe = psel && penable && pwrite;
  wire wrFault = wrStrobe && paddr == `SRCS_OFF_FAULT_CTL;
  wire wrCause = wrStrobe && paddr == `SRCS_OFF_CAUSE;
  wire wrBoStat = wrStrobe && paddr == `SRCS_OFF_BO_STAT;
  wire wrSoft0 = wrStrobe && paddr == `SRCS_OFF_SOFT0;
  wire wrSoft1 = wrStrobe && paddr == `SRCS_OFF_SOFT1;
  wire wrSoft2 = wrStrobe && paddr == `SRCS_OFF_SOFT2;
  wire wrClkCfg = wrStrobe && paddr == `SRCS_OFF_CLK_CFG;
  wire wrSysReq = wrStrobe && paddr == `SRCS_OFF_SYS_REQ;
  wire wrWdLoad = wrStrobe && paddr == `SRCS_OFF_WD_LOAD;
  wire wrWdCtl = wrStrobe && paddr == `SRCS_OFF_WD_CTL;
  wire wrWdStat = wrStrobe && paddr == `SRCS_OFF_WD_STAT;

  // Brown-out event on the supply monitor's rising edge
  wire borEvent = supplyLow && !supplyLowDly_reg;
  wire borResetReq = supplyLow && borEnable_reg;
  wire extActive = !extResetN;
  // Internal reset also clears the soft-reset, watchdog and clock configuration registers
  wire sysReset = coreReset;
  wire wdZero = wdCount_reg == 32'h00000000;
  wire wdRun = wdCtl_reg[`SRCS_BIT_WD_RUN];
  wire [5:0] clkTarget = srcsClkDecode(clkCfg_reg);

  // Zero wait states: every access completes in its first access cycle
  assign pready = 1'b1;

  // Read data and error captured in the setup cycle
  always @(posedge clock) begin
    if (reset) begin
      prdata <= 32'h00000000;
      pslverr <= 1'b0;
    end else if (setup) begin
      pslverr <= 1'b0;
      case (paddr)
        `SRCS_OFF_FAULT_CTL: prdata <= {30'h00000000, borEnable_reg, 1'b0};
        `SRCS_OFF_CAUSE: prdata <= {27'h0000000, cause_reg};
        `SRCS_OFF_BO_STAT: prdata <= {31'h00000000, borFlag_reg};
        `SRCS_OFF_SOFT0: prdata <= soft0_reg;
        `SRCS_OFF_SOFT1: prdata <= soft1_reg;
        `SRCS_OFF_SOFT2: prdata <= soft2_reg;
        `SRCS_OFF_CLK_CFG: prdata <= {24'h000000, clkCfg_reg};
        `SRCS_OFF_SYS_REQ: prdata <= 32'h00000000;
        `SRCS_OFF_WD_LOAD: prdata <= wdLoad_reg;
        `SRCS_OFF_WD_CTL: prdata <= {30'h00000000, wdCtl_reg};
        `SRCS_OFF_WD_VALUE: prdata <= wdCount_reg;
        `SRCS_OFF_WD_STAT: prdata <= {31'h00000000, wdFlag_reg};
        `SRCS_OFF_CLK_STAT: prdata <= {25'h0000000, mainOscReady, clockGate};
        default: begin
          prdata <= 32'h00000000;
          pslverr <= 1'b1;
        end
      endcase
    end
  end

  // Brown-out control and flag; only power-on clears the enable
  always @(posedge clock) begin
    if (reset) begin
      borEnable_reg <= 1'b0;
      borFlag_reg <= 1'b0;
      supplyLowDly_reg <= 1'b0;
    end else begin
      supplyLowDly_reg <= supplyLow;
      if (wrFault) begin
        borEnable_reg <= pwdata[`SRCS_BIT_BO_RESET_EN];
      end
      // Interrupt path when reset path is off; set beats clear
      if (borEvent && !borEnable_reg) begin
        borFlag_reg <= 1'b1;
      end else if (wrBoStat && pwdata[0]) begin
        borFlag_reg <= 1'b0;
      end
    end
  end

  // Cause record: sticky, write one to clear, a new cause wins
  always @(posedge clock) begin
    if (reset) begin
      cause_reg <= `SRCS_CAUSE_POR_VALUE;
    end else begin
      cause_reg <= (cause_reg & ~({5{wrCause}} & pwdata[4:0])) | {
        sysReq_reg,
        wdReset_reg,
        borResetReq,
        1'b0,
        extActive};
    end
  end

  // Sequencer next state
  always @* begin
    state_next = state_reg;
    case (state_reg)
      ST_RUN: begin
        if (extActive || borResetReq || sysReq_reg || wdReset_reg) begin
          state_next = ST_HOLD;
        end
      end
      ST_HOLD: begin
        // Level sources keep reset asserted until they go away
        if (!extActive && !borResetReq) begin
          state_next = ST_STRETCH;
        end
      end
      ST_STRETCH: begin
        if (extActive || borResetReq) begin
          state_next = ST_HOLD;
        end else if (stretch_reg == 5'h00) begin
          state_next = ST_RUN;
        end
      end
      default: state_next = ST_HOLD;
    endcase
  end

  // Sequencer registers and the reset outputs
  always @(posedge clock) begin
    if (reset) begin
      state_reg <= ST_STRETCH;
      stretch_reg <= `SRCS_RESET_STRETCH;
      coreReset <= 1'b1;
      testAccessReset <= 1'b1;
    end else begin
      state_reg <= state_next;
      if (state_next != ST_STRETCH) begin
        stretch_reg <= `SRCS_RESET_STRETCH;
      end else if (stretch_reg != 5'h00) begin
        stretch_reg <= stretch_reg - 5'h01;
      end
      // Brown-out acts exactly like the pin: core and peripherals only
      coreReset <= state_next != ST_RUN;
      testAccessReset <= 1'b0;
    end
  end

  // System reset request is a one-cycle event into the sequencer
  always @(posedge clock) begin
    if (reset) begin
      sysReq_reg <= 1'b0;
    end else begin
      sysReq_reg <= wrSysReq && pwdata[0];
    end
  end

  // Peripheral soft-reset registers, cleared by any internal reset
  always @(posedge clock) begin
    if (reset || sysReset) begin
      soft0_reg <= 32'h00000000;
      soft1_reg <= 32'h00000000;
      soft2_reg <= 32'h00000000;
    end else begin
      if (wrSoft0) begin
        soft0_reg <= pwdata;
      end
      if (wrSoft1) begin
        soft1_reg <= pwdata;
      end
      if (wrSoft2) begin
        soft2_reg <= pwdata;
      end
    end
  end

  // One line per unit covers all its clock domains; bit 32*k+n follows bit n of soft register k
  always @(posedge clock) begin
    if (reset) begin
      periphReset <= {96{1'b1}};
    end else begin
      periphReset <= {soft2_reg, soft1_reg, soft0_reg} | {96{sysReset}};
    end
  end

  // Watchdog configuration and counter
  always @(posedge clock) begin
    if (reset || sysReset) begin
      wdLoad_reg <= `SRCS_WD_LOAD_RESET;
      wdCtl_reg <= 2'h0;
      wdCount_reg <= `SRCS_WD_LOAD_RESET;
      wdFlag_reg <= 1'b0;
      wdReset_reg <= 1'b0;
    end else begin
      wdReset_reg <= 1'b0;
      if (wrWdCtl) begin
        wdCtl_reg <= pwdata[1:0];
      end
      if (wrWdLoad) begin
        wdLoad_reg <= pwdata;
        wdCount_reg <= pwdata;
      end else if (wdRun && wdZero) begin
        wdCount_reg <= wdLoad_reg;
      end else if (wdRun) begin
        wdCount_reg <= wdCount_reg - 32'h00000001;
      end
      // Second zero with the flag still pending may reset the system
      if (wdRun && wdZero && wdFlag_reg && wdCtl_reg[`SRCS_BIT_WD_RESET_EN]) begin
        wdReset_reg <= 1'b1;
      end
      // Timeout sets the flag; set beats a simultaneous clear
      if (wdRun && wdZero) begin
        wdFlag_reg <= 1'b1;
      end else if (wrWdStat && pwdata[0]) begin
        wdFlag_reg <= 1'b0;
      end
    end
  end

  // Interrupt levels follow the sticky flags
  always @(posedge clock) begin
    if (reset) begin
      brownoutIrq <= 1'b0;
      watchdogIrq <= 1'b0;
    end else begin
      brownoutIrq <= borFlag_reg;
      watchdogIrq <= wdFlag_reg;
    end
  end

  // Clock configuration returns to the fast oscillator on every reset
  always @(posedge clock) begin
    if (reset || sysReset) begin
      clkCfg_reg <= `SRCS_CLK_CFG_RESET;
    end else if (wrClkCfg) begin
      // Software must see mainOscReady first; hardware does not check
      clkCfg_reg <= pwdata[7:0];
    end
  end

  // Break-before-make gate switching avoids runt clock pulses
  always @(posedge clock) begin
    if (reset) begin
      clockGate <= `SRCS_GATE_RESET;
      gap_reg <= 3'h0;
      pllFromMain <= 1'b1;
    end else begin
      pllFromMain <= 1'b1;
      if (clockGate != 6'h00 && clockGate != clkTarget) begin
        clockGate <= 6'h00;
        gap_reg <= `SRCS_CLK_GAP;
      end else if (clockGate == 6'h00) begin
        if (gap_reg != 3'h0) begin
          gap_reg <= gap_reg - 3'h1;
        end else begin
          clockGate <= clkTarget;
        end
      end
    end
  end

endmodule

// >>> verification/srcs_rcc_sva.sv
// Assertion checker for the reset and clock-source controller
`timescale 1ns/1ns
module srcs_rcc_sva (
  // Clock and reset
  input wire clock,
  input wire reset,
  // APB
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  input wire pready,
  input wire [31:0] prdata,
  input wire pslverr,
  // Sources
  input wire extResetN,
  input wire supplyLow,
  input wire mainOscReady,
  // Outputs
  input wire coreReset,
  input wire testAccessReset,
  input wire [95:0] periphReset,
  input wire brownoutIrq,
  input wire watchdogIrq,
  input wire [5:0] clockGate,
  input wire pllFromMain
);
  reg boEn;

  // Mirror of the brown-out reset enable; only power-on reset clears it
  always @(posedge clock) begin
    if (reset)
      boEn <= 1'b0;
    else if (psel && penable && pwrite && paddr == 8'h00)
      boEn <= pwdata[1];
  end

  default clocking @(posedge clock); endclocking
  default disable iff (reset);

  // Brown-out handling
  bor_hold_a: assert property (supplyLow && boEn |-> ##[1:2] coreReset)
    else $error("brown-out did not hold reset");
  bor_off_a: assert property (
    supplyLow && !boEn && extResetN && !coreReset && !watchdogIrq |=> !coreReset)
    else $error("brown-out reset while disabled");
  bor_irq_a: assert property ($rose(supplyLow) && !boEn |-> ##[1:3] brownoutIrq)
    else $error("brown-out interrupt missing");
  // Reset fan-out
  ext_hold_a: assert property (!extResetN |-> ##[1:2] coreReset)
    else $error("pin reset not seen");
  tap_keep_a: assert property (!reset |=> !testAccessReset)
    else $error("test access reset outside power-on");
  periph_all_a: assert property (coreReset |=> &periphReset)
    else $error("peripherals not reset with core");
  stretch_a: assert property ($rose(coreReset) |-> coreReset [*8])
    else $error("internal reset too short");
  // Clock selection
  clk_gap_a: assert property (
    $changed(clockGate) |-> clockGate == 6'h00 || $past(clockGate) == 6'h00)
    else $error("clock switched without gap");
  clk_onehot_a: assert property ($countones(clockGate) <= 1)
    else $error("two clock gates open");
  por_clk_a: assert property (coreReset && $past(coreReset, 8) |-> clockGate == 6'h04)
    else $error("reset not on fast oscillator");
  pll_ref_a: assert property (pllFromMain)
    else $error("pll not fed by main oscillator");
endmodule

// >>> verification/srcs_reset_clock_ctl_tb.sv
// Self-checking bench for the reset and clock-source controller
`timescale 1ns/1ns
`include "srcs_consts.vh"
module srcs_reset_clock_ctl_tb;
  reg clock, reset, psel, penable, pwrite, extResetN, supplyLow, mainOscReady, err;
  reg [7:0] paddr;
  reg [31:0] pwdata, rd, v;
  wire pready, pslverr, coreReset, testAccessReset, brownoutIrq, watchdogIrq, pllFromMain;
  wire [31:0] prdata;
  wire [95:0] periphReset;
  wire [5:0] clockGate;
  integer errors, check_count, i, n, seed;

  srcs_reset_clock_ctl uut (.clock, .reset, .psel, .penable, .pwrite, .paddr, .pwdata,
    .pready, .prdata, .pslverr, .extResetN, .supplyLow, .mainOscReady, .coreReset,
    .testAccessReset, .periphReset, .brownoutIrq, .watchdogIrq, .clockGate, .pllFromMain);

  // Expected gate for a clock configuration value
  function [5:0] gateOf(input [7:0] c);
    begin
      if (!c[0])
        gateOf = 6'h01;
      else if (c[7] && c[6:4] == 3'h7)
        gateOf = 6'h20;
      else
        gateOf = 6'h02 << c[2:1];
    end
  endfunction

  task check(input [95:0] got, input [95:0] exp);
    begin
      check_count = check_count + 1;
      if (got !== exp) begin
        errors = errors + 1;
        $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask

  task results;
    begin
      if (errors == 0 && check_count > 0)
        $display("DONE - PASS");
      else
        $display("DONE - FAIL");
      $finish;
    end
  endtask

  task tick(input integer c);
    begin
      repeat (c) @(posedge clock);
    end
  endtask

  // One APB transfer; held until pready is sampled high
  task apb(input w, input [7:0] a, input [31:0] d);
    begin
      @(posedge clock);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clock);
      penable <= 1'b1;
      @(posedge clock);
      while (pready !== 1'b1)
        @(posedge clock);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask

  task rdchk(input [7:0] a, input [31:0] exp);
    begin
      apb(1'b0, a, 32'h0);
      check(rd, exp);
    end
  endtask

  // Bounded wait for the internal reset to end
  task waitrun;
    begin
      n = 0;
      while (coreReset !== 1'b0 && n < 300) begin
        n = n + 1;
        @(posedge clock);
      end
      check(coreReset, 1'b0);
    end
  endtask

  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  // Hang guard, far beyond the expected run
  initial begin
    #200000;
    errors = errors + 1;
    results;
  end

  initial begin
    seed = 32'h101B;
    errors = 0;
    check_count = 0;
    {reset, extResetN} = 2'b11;
    {psel, penable, pwrite, supplyLow, mainOscReady} = 5'h00;
    paddr = 8'h00;
    pwdata = 32'h0;
    tick(20);
    check(testAccessReset, 1'b1);
    reset <= 1'b0;
    waitrun;
    check(testAccessReset, 1'b0);
    rdchk(`SRCS_OFF_CAUSE, `SRCS_CAUSE_POR_VALUE);
    rdchk(`SRCS_OFF_FAULT_CTL, 32'h0);
    check(clockGate, `SRCS_GATE_RESET);
    // Brown-out while reset generation is off
    n = 5 + {$random(seed)} % 10;
    supplyLow <= 1'b1;
    tick(n);
    check(coreReset, 1'b0);
    check(brownoutIrq, 1'b1);
    supplyLow <= 1'b0;
    apb(1'b1, `SRCS_OFF_BO_STAT, 32'h1);
    rdchk(`SRCS_OFF_BO_STAT, 32'h0);
    // Brown-out with reset generation on
    apb(1'b1, `SRCS_OFF_FAULT_CTL, 32'h2);
    supplyLow <= 1'b1;
    tick(n + 30);
    check(coreReset, 1'b1);
    supplyLow <= 1'b0;
    waitrun;
    rdchk(`SRCS_OFF_CAUSE, 32'h06);
    apb(1'b1, `SRCS_OFF_FAULT_CTL, 32'h0);
    apb(1'b1, `SRCS_OFF_CAUSE, 32'h04);
    // Pin reset
    extResetN <= 1'b0;
    tick(n);
    check(coreReset, 1'b1);
    extResetN <= 1'b1;
    waitrun;
    rdchk(`SRCS_OFF_CAUSE, 32'h03);
    apb(1'b1, `SRCS_OFF_CAUSE, 32'h01);
    // Peripheral soft resets, one random unit per register
    for (i = 0; i < 3; i = i + 1) begin
      n = {$random(seed)} % 32;
      apb(1'b1, 8'(`SRCS_OFF_SOFT0 + 4 * i), 32'h1 << n);
      tick(3);
      check(periphReset, 96'h1 << (32 * i + n));
      apb(1'b1, 8'(`SRCS_OFF_SOFT0 + 4 * i), 32'h0);
      tick(3);
      check(periphReset, 96'h0);
    end
    // Every clock source, main oscillator made ready first
    mainOscReady <= 1'b1;
    for (i = 0; i < 6; i = i + 1) begin
      v = (i == 5) ? 32'hF1 : (i == 0) ? 32'h0 : 2 * (i - 1) + 1;
      apb(1'b1, `SRCS_OFF_CLK_CFG, v);
      tick(10);
      check(clockGate, gateOf(v[7:0]));
      rdchk(`SRCS_OFF_CLK_STAT, {25'h0, 1'b1, gateOf(v[7:0])});
    end
    // Software system reset returns to the fast oscillator
    apb(1'b1, `SRCS_OFF_SYS_REQ, 32'h1);
    tick(4);
    check(coreReset, 1'b1);
    waitrun;
    rdchk(`SRCS_OFF_CAUSE, 32'h12);
    rdchk(`SRCS_OFF_CLK_CFG, `SRCS_CLK_CFG_RESET);
    tick(10);
    check(clockGate, 6'h04);
    apb(1'b1, `SRCS_OFF_CAUSE, 32'h10);
    // Watchdog: first timeout, then second with reset off and on
    v = 20 + {$random(seed)} % 20;
    apb(1'b1, `SRCS_OFF_WD_LOAD, v);
    apb(1'b1, `SRCS_OFF_WD_CTL, 32'h1);
    tick(v + 4);
    check(watchdogIrq, 1'b1);
    apb(1'b0, `SRCS_OFF_WD_VALUE, 32'h0);
    check(rd > v - 12 && rd <= v, 1'b1);
    tick(2 * v + 10);
    check(coreReset, 1'b0);
    apb(1'b1, `SRCS_OFF_WD_CTL, 32'h0);
    apb(1'b1, `SRCS_OFF_WD_LOAD, v);
    apb(1'b1, `SRCS_OFF_WD_STAT, 32'h1);
    apb(1'b1, `SRCS_OFF_WD_CTL, 32'h3);
    tick(v + 4);
    check(coreReset, 1'b0);
    tick(v + 4);
    check(coreReset, 1'b1);
    waitrun;
    rdchk(`SRCS_OFF_CAUSE, 32'h0A);
    // Unmapped offset
    apb(1'b0, 8'h40, 32'h0);
    check({err, rd}, {1'b1, 32'h0});
    // Power-on reset again clears other causes
    reset <= 1'b1;
    tick(3);
    reset <= 1'b0;
    waitrun;
    rdchk(`SRCS_OFF_CAUSE, 32'h02);
    results;
  end
endmodule

bind srcs_reset_clock_ctl srcs_rcc_sva chk (.clock, .reset, .psel, .penable, .pwrite,
  .paddr, .pwdata, .pready, .prdata, .pslverr, .extResetN, .supplyLow, .mainOscReady,
  .coreReset, .testAccessReset, .periphReset, .brownoutIrq, .watchdogIrq, .clockGate,
  .pllFromMain);
